/* core/rxsw_core.sv */
// Receive status word builder, status FIFO and receiver control.
`timescale 1ns/100ps
module rxsw_core import rxsw_pkg::*; (
  input logic aclk,
  input logic aresetn,
  input logic ce,
  input rxsw_axi_m2s_type axi_in,
  output rxsw_axi_s2m_type axi_out,
  input rxsw_mac_type mac,
  input logic dfifo_underrun,
  output logic receive_active,
  output logic receiver_error_flag,
  output logic receiver_stopped_irq
);

  rxsw_state_type st_q;
  rxsw_state_type st_d;
  logic runt;
  logic too_long;
  logic wdog;
  logic late;
  logic crcb;
  logic etype;
  logic lerr;
  logic drib;
  logic es;
  logic keep;
  logic push;
  logic push_ok;
  logic pop_ok;
  logic wr_go;
  logic rd_go;
  logic err_set;
  logic err_clr;
  logic srst;
  logic [31:0] word;

  // Frame classification from the counters of the frame just ended.
  always_comb begin
    runt = st_q.len < RUNT_LEN;
    too_long = st_q.len > MAX_LEN;
    wdog = st_q.len > WDOG_LEN;
    late = mac.late_col;
    crcb = mac.crc_bad | st_q.rxer | mac.rx_er;
    etype = (st_q.lt > ETYPE_MAX) && !(st_q.len < HDR_LEN);
    // Short length fields are padded out to the minimum frame size.
    lerr = 1'b0;
    if (!etype && !runt) begin
      if (st_q.lt < MIN_PAY) begin
        lerr = st_q.len != RUNT_LEN;
      end else begin
        lerr = {2'h0, st_q.len - FRM_OVH} != st_q.lt;
      end
    end
    drib = !late && (mac.mode10 ? (mac.drib_bits >= DRIB_10) :
                     (mac.drib_bits == DRIB_MII));
    // Dribble stays out of the summary, so it alone leaves a valid frame.
    es = runt | too_long | late | crcb;
  end

  // Status word assembly; untouched positions stay zero.
  always_comb begin
    word = 32'h0000_0000;
    word[SW_FFAIL] = mac.filt_fail;
    word[SW_LEN +: 14] = st_q.len;
    word[SW_ES] = es;
    word[SW_BCAST] = st_q.bc;
    word[SW_LERR] = lerr;
    word[SW_RUNT] = runt;
    word[SW_MCAST] = st_q.mc && !st_q.bc;
    word[SW_LONG] = too_long;
    word[SW_LATE] = late;
    word[SW_ETYPE] = etype;
    word[SW_WDOG] = wdog;
    word[SW_MIIER] = st_q.rxer | mac.rx_er;
    word[SW_DRIB] = drib;
    word[SW_CRC] = crcb;
  end

  // Handshakes: a write needs address and data together.
  // Nothing is accepted while the clock enable holds the state frozen.
  assign wr_go = ce && axi_in.awvalid && axi_in.wvalid && !st_q.bvalid;
  assign rd_go = ce && axi_in.arvalid && !st_q.rvalid;
  assign keep = !runt || st_q.pass_bad;
  assign push = (st_q.rx == RX_FRAME) && mac.eof && keep;
  assign push_ok = push && (st_q.cnt != SF_FULL);
  assign srst = wr_go && (axi_in.awaddr == ADDR_SRST) &&
                axi_in.wstrb[0] && axi_in.wdata[B_SRST];
  assign err_clr = wr_go && (axi_in.awaddr == ADDR_STAT) &&
                   axi_in.wstrb[0] && axi_in.wdata[B_ERR];
  assign pop_ok = rd_go && (axi_in.araddr == ADDR_SFIFO) &&
                  !st_q.desync && (st_q.cnt != 3'h0);
  // Underrun of either FIFO or status overrun raises the error flag.
  assign err_set = (push && !push_ok) || dfifo_underrun ||
                   (rd_go && (axi_in.araddr == ADDR_SFIFO) &&
                    !st_q.desync && (st_q.cnt == 3'h0));

  // Next-state logic for the receiver, the FIFO and the register port.
  always_comb begin
    st_d = st_q;
    st_d.irq = 1'b0;
    // Receive side frame tracking.
    unique case (st_q.rx)
      RX_IDLE: begin
        if (mac.sof) begin
          st_d.len = 14'h0000;
          st_d.lt = 16'h0000;
          st_d.bc = 1'b1;
          st_d.mc = 1'b0;
          st_d.rxer = 1'b0;
          // A frame begun while disabled is tracked but never delivered.
          st_d.rx = st_q.en ? RX_FRAME : RX_SKIP;
        end
      end
      RX_FRAME, RX_SKIP: begin
        st_d.rxer = st_q.rxer | mac.rx_er;
        if (mac.byte_vld) begin
          // Length saturates; reception itself is never cut short.
          if (st_q.len != 14'h3fff) begin
            st_d.len = st_q.len + 14'h0001;
          end
          if (st_q.len < BC_BYTES) begin
            st_d.bc = st_q.bc && (mac.rx_byte == 8'hff);
          end
          if (st_q.len == 14'h0000) begin
            st_d.mc = mac.rx_byte[0];
          end
          if (st_q.len == LT_HI) begin
            st_d.lt[15:8] = mac.rx_byte;
          end
          if (st_q.len == LT_LO) begin
            st_d.lt[7:0] = mac.rx_byte;
          end
        end
        if (mac.eof) begin
          st_d.rx = RX_IDLE;
        end
      end
    endcase
    // Halt once disabled and no delivered frame is in flight.
    if (st_q.en) begin
      st_d.running = 1'b1;
    end else if (st_q.running && (st_q.rx != RX_FRAME)) begin
      st_d.running = 1'b0;
      st_d.irq = 1'b1;
    end
    // Status FIFO write; an overrun drops the word but not reception.
    if (push_ok) begin
      st_d.mem[st_q.wp] = word;
      st_d.wp = st_q.wp + 2'h1;
    end
    if (pop_ok) begin
      st_d.rp = st_q.rp + 2'h1;
    end
    st_d.cnt = st_q.cnt + {2'h0, push_ok} - {2'h0, pop_ok};
    // Register writes.
    if (wr_go) begin
      st_d.bvalid = 1'b1;
      st_d.bresp = RESP_OK;
      unique case (axi_in.awaddr)
        ADDR_CTRL: begin
          if (axi_in.wstrb[0]) begin
            st_d.en = axi_in.wdata[B_ENABLE];
          end
          if (axi_in.wstrb[2]) begin
            st_d.pass_bad = axi_in.wdata[B_PASSBAD];
          end
        end
        ADDR_STAT, ADDR_SRST: begin
        end
        default: st_d.bresp = RESP_SLVERR;
      endcase
    end else if (st_q.bvalid && axi_in.bready) begin
      st_d.bvalid = 1'b0;
    end
    // Register reads; the status port pops one word per read unless desynced or empty.
    if (rd_go) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = RESP_OK;
      st_d.rdata = 32'h0000_0000;
      unique case (axi_in.araddr)
        ADDR_CTRL: begin
          st_d.rdata[B_ENABLE] = st_q.en;
          st_d.rdata[B_PASSBAD] = st_q.pass_bad;
        end
        ADDR_STAT: begin
          st_d.rdata[B_ERR] = st_q.err;
          st_d.rdata[B_RUNNING] = st_q.running;
          st_d.rdata[B_DESYNC] = st_q.desync;
          st_d.rdata[B_COUNT +: 3] = st_q.cnt;
        end
        ADDR_SFIFO: begin
          if (pop_ok) begin
            st_d.rdata = st_q.mem[st_q.rp];
          end
        end
        ADDR_SRST: begin
        end
        default: st_d.rresp = RESP_SLVERR;
      endcase
    end else if (st_q.rvalid && axi_in.rready) begin
      st_d.rvalid = 1'b0;
    end
    // Soft reset flushes the status FIFO and regains read sync.
    if (srst) begin
      st_d.wp = 2'h0;
      st_d.rp = 2'h0;
      st_d.cnt = 3'h0;
      st_d.desync = 1'b0;
    end
    if (dfifo_underrun) begin
      st_d.desync = 1'b1;
    end
    // A new error event wins over a clear in the same cycle.
    st_d.err = (st_q.err && !err_clr && !srst) || err_set;
  end

  // State register; the clock enable freezes everything except reset, which clears it regardless.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // Port drive.
  always_comb begin
    axi_out.awready = wr_go;
    axi_out.wready = wr_go;
    axi_out.arready = rd_go;
    axi_out.bvalid = st_q.bvalid;
    axi_out.bresp = st_q.bresp;
    axi_out.rvalid = st_q.rvalid;
    axi_out.rdata = st_q.rdata;
    axi_out.rresp = st_q.rresp;
  end
  assign receive_active = st_q.running;
  assign receiver_error_flag = st_q.err;
  assign receiver_stopped_irq = st_q.irq;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_halt;
    ce && !st_q.en && st_q.running && (st_q.rx != RX_FRAME);
  endsequence

  sequence s_pulse;
    receiver_stopped_irq ##1 !receiver_stopped_irq;
  endsequence

  property p_resv;
    push |-> !word[31] && !word[14] && (word[9:8] == 2'h0) && !word[0];
  endproperty
  a_resv: assert property (p_resv)
    else $error("Reserved status bit set.");

  property p_es;
    push |-> word[SW_ES] ==
      ((st_q.len < RUNT_LEN) || (st_q.len > MAX_LEN) || mac.late_col ||
       mac.crc_bad || word[SW_MIIER]);
  endproperty
  a_es: assert property (p_es)
    else $error("Summary error bit mismatch.");

  property p_long;
    push |-> word[SW_LONG] == (word[29:16] > MAX_LEN);
  endproperty
  a_long: assert property (p_long)
    else $error("Too long bit does not match length.");

  property p_drib;
    push |-> !(word[SW_DRIB] && word[SW_LATE]);
  endproperty
  a_drib: assert property (p_drib)
    else $error("Dribble bit set with late collision.");

  property p_runt_drop;
    ce && (st_q.rx == RX_FRAME) && mac.eof && runt && !st_q.pass_bad &&
      !pop_ok && !srst |=> st_q.cnt == $past(st_q.cnt);
  endproperty
  a_runt_drop: assert property (p_runt_drop)
    else $error("Runt delivered without pass-bad.");

  property p_stop;
    s_halt |=> s_pulse;
  endproperty
  a_stop: assert property (p_stop)
    else $error("Stop pulse missing or too long.");

  property p_err;
    ce && dfifo_underrun |=> receiver_error_flag && st_q.desync;
  endproperty
  a_err: assert property (p_err)
    else $error("Underrun did not raise error flag.");

  property p_run_on;
    ce && st_q.err && st_q.en && (st_q.rx == RX_IDLE) && mac.sof
      |=> st_q.rx == RX_FRAME;
  endproperty
  a_run_on: assert property (p_run_on)
    else $error("Error flag blocked a new frame.");

  property p_push;
    ce && push_ok && !pop_ok && !srst |=> st_q.cnt == $past(st_q.cnt) + 3'h1;
  endproperty
  a_push: assert property (p_push)
    else $error("Status word not queued.");

  property p_srst;
    ce && srst && !dfifo_underrun |=> !st_q.desync && (st_q.cnt == 3'h0);
  endproperty
  a_srst: assert property (p_srst)
    else $error("Soft reset did not resync.");

endmodule

/* core/rxsw_pkg.sv */
// Constants and types shared by the receive status and control block.
package rxsw_pkg;

  // Register byte addresses on the AXI4-Lite port.
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_SFIFO = 4'h8;
  localparam logic [3:0] ADDR_SRST = 4'hc;

  // Control, status and soft reset field positions.
  localparam int B_ENABLE = 2;
  localparam int B_PASSBAD = 16;
  localparam int B_ERR = 0;
  localparam int B_RUNNING = 1;
  localparam int B_DESYNC = 2;
  localparam int B_COUNT = 8;
  localparam int B_SRST = 0;

  // Status word field positions.
  localparam int SW_FFAIL = 30;
  localparam int SW_LEN = 16;
  localparam int SW_ES = 15;
  localparam int SW_BCAST = 13;
  localparam int SW_LERR = 12;
  localparam int SW_RUNT = 11;
  localparam int SW_MCAST = 10;
  localparam int SW_LONG = 7;
  localparam int SW_LATE = 6;
  localparam int SW_ETYPE = 5;
  localparam int SW_WDOG = 4;
  localparam int SW_MIIER = 3;
  localparam int SW_DRIB = 2;
  localparam int SW_CRC = 1;

  // Frame length thresholds in bytes, plus dribble bit counts.
  localparam logic [13:0] RUNT_LEN = 14'h0040;
  localparam logic [13:0] MAX_LEN = 14'h05ee;
  localparam logic [13:0] WDOG_LEN = 14'h0800;
  localparam logic [13:0] HDR_LEN = 14'h000e;
  localparam logic [13:0] FRM_OVH = 14'h0012;
  localparam logic [13:0] BC_BYTES = 14'h0006;
  localparam logic [13:0] LT_HI = 14'h000c;
  localparam logic [13:0] LT_LO = 14'h000d;
  localparam logic [15:0] ETYPE_MAX = 16'h05dc;
  localparam logic [15:0] MIN_PAY = 16'h002e;
  localparam logic [2:0] DRIB_MII = 3'h4;
  localparam logic [2:0] DRIB_10 = 3'h3;

  // Status FIFO geometry and bus responses.
  localparam int SF_DEPTH = 4;
  localparam logic [2:0] SF_FULL = 3'h4;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {RX_IDLE, RX_FRAME, RX_SKIP} rxsw_rx_type;

  // Per-cycle frame events from the MAC receive layer.
  typedef struct packed {
    logic sof;
    logic byte_vld;
    logic [7:0] rx_byte;
    logic rx_er;
    logic eof;
    logic crc_bad;
    logic late_col;
    logic filt_fail;
    logic mode10;
    logic [2:0] drib_bits;
  } rxsw_mac_type;

  typedef struct packed {
    logic awvalid;
    logic [3:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [3:0] araddr;
    logic rready;
  } rxsw_axi_m2s_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rxsw_axi_s2m_type;

  typedef struct packed {
    rxsw_rx_type rx;
    logic en;
    logic pass_bad;
    logic running;
    logic irq;
    logic err;
    logic desync;
    logic [13:0] len;
    logic [15:0] lt;
    logic bc;
    logic mc;
    logic rxer;
    logic [1:0] wp;
    logic [1:0] rp;
    logic [2:0] cnt;
    logic [SF_DEPTH-1:0][31:0] mem;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rxsw_state_type;

endpackage

/* tb/rxsw_mac_model.sv */
// Frame source standing in for the MAC receive layer.
`timescale 1ns/100ps
module rxsw_mac_model import rxsw_pkg::*; (
  input wire logic aclk,
  output rxsw_mac_type mac
);
  initial mac = '0;

  // Sends one frame: dest bytes d0, type ty, flags f, then a payload.
  // Flags f: rx_er, crc, late, filter fail, mode10, dribble bits.
  task automatic send(input int len, input logic [7:0] d0,
      input logic [15:0] ty, input logic [7:0] f);
    rxsw_mac_type t;
    logic [7:0] b;
    t = '0;
    t.sof = 1'b1;
    t.rx_er = f[7];
    @(posedge aclk);
    mac <= t;
    for (int i = 0; i < len; i++) begin
      b = i < 6 ? d0 : i == 12 ? ty[15:8] : i == 13 ? ty[7:0] : i[7:0];
      t.sof = 1'b0;
      t.byte_vld = 1'b1;
      t.rx_byte = b;
      @(posedge aclk);
      mac <= t;
    end
    t.byte_vld = 1'b0;
    t.eof = 1'b1;
    {t.crc_bad, t.late_col, t.filt_fail, t.mode10, t.drib_bits} = f[6:0];
    @(posedge aclk);
    mac <= t;
    // Idle data line shows the inverse of the last byte, not a stale copy.
    t = '0;
    t.rx_byte = ~b;
    @(posedge aclk);
    mac <= t;
  endtask
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the receive status and control block.
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin \
  n_mismatch++; $display("ERROR %0t: got %h want %h", $time, a, b); \
  end end
module tb_top import rxsw_pkg::*;;
  logic aclk = 1'b0;
  logic aresetn;
  logic dfu;
  logic active;
  logic eflag;
  logic irq;
  logic [31:0] v;
  rxsw_axi_m2s_type m;
  rxsw_axi_s2m_type s;
  rxsw_mac_type mac;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_irq = 0;

  rxsw_core dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .axi_in(m),
    .axi_out(s), .mac(mac), .dfifo_underrun(dfu),
    .receive_active(active), .receiver_error_flag(eflag),
    .receiver_stopped_irq(irq));
  rxsw_mac_model u_mac (.aclk(aclk), .mac(mac));

  // Clock and stop pulse counter.
  always #2 aclk = ~aclk;
  always @(negedge aclk) if (irq === 1'b1) n_irq++;

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Bounded wait for a handshake: 0 aw/w, 1 ar, 2 b, 3 r.
  task automatic hs(input int k);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (!(k == 0 ? s.awready && s.wready : k == 1 ? s.arready :
      k == 2 ? s.bvalid : s.rvalid) && n < 3000);
    if (n >= 3000) begin
      n_mismatch++;
      $display("ERROR %0t: handshake timeout", $time);
      wrap_up;
    end
  endtask

  // One AXI4-Lite write with its response checked.
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
      input logic [1:0] r);
    m.awvalid <= 1'b1;
    m.wvalid <= 1'b1;
    m.awaddr <= a;
    m.wdata <= d;
    m.wstrb <= 4'hf;
    hs(0);
    @(posedge aclk);
    m.awvalid <= 1'b0;
    m.wvalid <= 1'b0;
    m.bready <= 1'b1;
    hs(2);
    `CHK(s.bresp, r)
    @(posedge aclk);
    m.bready <= 1'b0;
  endtask

  // One AXI4-Lite read; data is taken at the falling edge where rvalid is seen.
  task automatic rd(input logic [3:0] a, output logic [31:0] d,
      input logic [1:0] r);
    m.arvalid <= 1'b1;
    m.araddr <= a;
    hs(1);
    @(posedge aclk);
    m.arvalid <= 1'b0;
    m.rready <= 1'b1;
    hs(3);
    d = s.rdata;
    `CHK(s.rresp, r)
    @(posedge aclk);
    m.rready <= 1'b0;
  endtask

  // Expected status word worked out from the frame's contents.
  function automatic logic [31:0] ew(int len, logic [7:0] d0,
      logic [15:0] ty, logic [7:0] f);
    logic [31:0] w;
    w = '0;
    w[29:16] = len[13:0];
    w[30] = f[4];
    w[13] = d0 == 8'hff;
    w[10] = d0[0] && d0 != 8'hff;
    w[11] = len < 64;
    w[7] = len > 1518;
    w[6] = f[5];
    w[5] = ty > 16'h05dc && len >= 14;
    w[4] = len > 2048;
    w[3] = f[7];
    w[2] = !f[5] && (f[3] ? f[2:0] >= 3'h3 : f[2:0] == 3'h4);
    w[1] = f[6] || f[7];
    w[12] = ty <= 16'h05dc && len >= 64
      && (ty < 46 ? len != 64 : len - 18 != ty);
    w[15] = w[11] | w[7] | w[6] | w[1];
    return w;
  endfunction

  // Sends a frame and reads back its status word.
  task automatic frm(input int len, input logic [7:0] d0,
      input logic [15:0] ty, input logic [7:0] f);
    logic [31:0] w;
    u_mac.send(len, d0, ty, f);
    rd(ADDR_SFIFO, w, RESP_OK);
    `CHK(w, ew(len, d0, ty, f))
  endtask

  // Main sequence.
  initial begin
    m = '0;
    dfu = 1'b0;
    aresetn = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ADDR_CTRL, v, RESP_OK); `CHK(v, 32'h0)
    rd(ADDR_STAT, v, RESP_OK); `CHK(v, 32'h0)
    rd(4'h2, v, RESP_SLVERR); `CHK(v, 32'h0)
    wr(ADDR_CTRL, 32'h0001_0004, RESP_OK);
    rd(ADDR_STAT, v, RESP_OK); `CHK(v, 32'h2)
    $display("test reset done");
    frm(64, 8'hff, 16'h0800, 8'h00);
    frm(100, 8'h01, 16'h0052, 8'h40);
    frm(1518, 8'h00, 16'h0800, 8'h00);
    frm(1600, 8'h00, 16'h0800, 8'h00);
    frm(2048, 8'h00, 16'h0800, 8'h00);
    frm(2100, 8'h00, 16'h0800, 8'h00);
    frm(40, 8'h00, 16'h0800, 8'h00);
    frm(12, 8'h00, 16'h0800, 8'h00);
    frm(80, 8'h00, 16'h0032, 8'h80);
    frm(64, 8'h00, 16'h0020, 8'h00);
    frm(70, 8'h00, 16'h0020, 8'h00);
    frm(70, 8'h00, 16'h0800, 8'h24);
    frm(70, 8'h00, 16'h0800, 8'h04);
    frm(70, 8'h00, 16'h0800, 8'h0b);
    frm(70, 8'h00, 16'h0800, 8'h03);
    frm(70, 8'h00, 16'h0800, 8'h10);
    $display("test status word done");
    repeat (5) u_mac.send(80, 8'h00, 16'h003e, 8'h00);
    rd(ADDR_STAT, v, RESP_OK); `CHK(v, 32'h403)
    `CHK(eflag, 1'b1)
    `CHK(active, 1'b1)
    wr(ADDR_STAT, 32'h1, RESP_OK);
    for (int i = 0; i < 4; i++) begin
      rd(ADDR_SFIFO, v, RESP_OK);
      `CHK(v, ew(80, 8'h00, 16'h003e, 8'h00))
    end
    `CHK(eflag, 1'b0)
    rd(ADDR_SFIFO, v, RESP_OK); `CHK(v, 32'h0)
    `CHK(eflag, 1'b1)
    wr(ADDR_SRST, 32'h1, RESP_OK);
    rd(ADDR_STAT, v, RESP_OK); `CHK(v, 32'h2)
    $display("test overrun done");
    dfu <= 1'b1;
    @(posedge aclk);
    dfu <= 1'b0;
    @(posedge aclk);
    rd(ADDR_STAT, v, RESP_OK); `CHK(v, 32'h7)
    u_mac.send(80, 8'h00, 16'h003e, 8'h00);
    rd(ADDR_SFIFO, v, RESP_OK); `CHK(v, 32'h0)
    wr(ADDR_SRST, 32'h1, RESP_OK);
    rd(ADDR_STAT, v, RESP_OK); `CHK(v, 32'h2)
    $display("test underrun done");
    wr(ADDR_CTRL, 32'h4, RESP_OK);
    u_mac.send(40, 8'h00, 16'h0800, 8'h00);
    rd(ADDR_STAT, v, RESP_OK); `CHK(v, 32'h2)
    n_irq = 0;
    wr(ADDR_CTRL, 32'h0, RESP_OK);
    repeat (4) @(posedge aclk);
    `CHK(n_irq, 1)
    `CHK(active, 1'b0)
    wr(ADDR_SRST, 32'h1, RESP_OK);
    u_mac.send(80, 8'h00, 16'h003e, 8'h00);
    rd(ADDR_STAT, v, RESP_OK); `CHK(v, 32'h0)
    wr(ADDR_CTRL, 32'h4, RESP_OK);
    frm(80, 8'h00, 16'h003e, 8'h00);
    `CHK(n_irq, 1)
    $display("test stop and start done");
    wrap_up;
  end
endmodule
